// *** design/mds_selector.sv ***
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "mds_regs.svh"

// Notes on behaviour
// - Set type 0 is invalid, 1 absolute move, 2 relative move.
// - Target is low part plus high part times 10000; each within 99999.
// - Set n parameters start at 700 plus 8n, four consecutive numbers.
// - Shared acceleration 1 to 60000, default 10000.
// - Shared deceleration 1 to 60000, default 10000.
// - Host holds run-enable on; device stops motor when it goes off.
// - Select bits 2..0 give binary set number, bit 0 least significant.
// - Rising step edge with run-enable on launches the selected set.
// - Fourth select line is select bit 3; sets 8 to 15 hold no data and never launch.
// - Active only when control mode second digit is C.
// - A launched set runs alone; no following set starts.
module mds_selector
  import mds_pkg::*;
(
  input  wire logic                   i_clk,
  input  wire logic                   i_resetn,
  input  wire logic [`MDS_ADDR_W-1:0] i_addr,
  input  wire logic [31:0]            i_wr_data,
  input  wire logic                   i_wr_en,
  input  wire logic                   i_rd_en,
  output logic      [31:0]            o_rd_data,
  input  wire logic                   i_set_select_bit0_n,
  input  wire logic                   i_set_select_bit1_n,
  input  wire logic                   i_set_select_bit2_n,
  input  wire logic                   i_set_select_bit3_n,
  input  wire logic                   i_run_enable_n,
  input  wire logic                   i_step_n,
  input  wire logic                   i_move_done,
  output logic                        o_launch,
  output logic      [3:0]             o_set_num,
  output logic      [1:0]             o_set_type,
  output logic      [31:0]            o_target_pos,
  output logic      [12:0]            o_speed,
  output logic      [15:0]            o_accel,
  output logic      [15:0]            o_decel,
  output logic      [15:0]            o_emg_decel,
  output logic      [15:0]            o_gear_num,
  output logic      [15:0]            o_gear_den,
  output logic                        o_stop,
  output logic                        o_busy,
  output logic                        o_mode_active
);

  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    mds_params_t store;
    mds_params_t work;
    mds_fsm_t    fsm;
    logic        step_prev;
    logic        launch;
    logic        stop;
    logic [3:0]  set_num;
    logic [1:0]  kind;
    logic [31:0] target;
    logic [12:0] speed;
    logic [31:0] rdata;
  } mds_state_t;

  mds_state_t q;
  mds_state_t d;

  logic       rst_n;
  logic [5:0] pins_s;
  logic [3:0] sel;
  logic       run_on;
  logic       step_on;
  logic       step_rise;
  logic       mode_act;
  logic       can_launch;
  logic [9:0] set_off;
  logic       in_set;
  logic [2:0] sn;
  logic [1:0] fld;
  logic signed [31:0] wr_s;
  logic       pos_ok;
  logic       rate_ok;
  logic       gear_ok;
  mds_set_t   pick;
  mds_set_t   rd_set;

  // ***************************************************************
  // Reset release and input synchronisers
  // ***************************************************************
  mds_sync #(.W(1), .RST_VAL(1'b0)) u_rst_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_resetn),
    .i_d     (1'b1),
    .o_q     (rst_n)
  );

  // Idle pins read as high, so nothing looks active during reset
  mds_sync #(.W(6), .RST_VAL(6'h3F)) u_pin_sync (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .i_d     ({i_step_n, i_run_enable_n, i_set_select_bit3_n,
               i_set_select_bit2_n, i_set_select_bit1_n,
               i_set_select_bit0_n}),
    .o_q     (pins_s)
  );

  assign sel       = ~pins_s[3:0];
  assign run_on    = ~pins_s[4];
  assign step_on   = ~pins_s[5];
  assign step_rise = step_on & ~q.step_prev;

  assign mode_act = (q.work.ctrl_mode[`MDS_MODE_DIGIT_HI:`MDS_MODE_DIGIT_LO]
                     == `MDS_MODE_SEQ) &&
                    (q.work.startup[3:0] == `MDS_STARTUP_SINGLE);

  // Only sets 0..7 hold parameters here; higher numbers never launch
  assign pick = q.work.set[sel[2:0]];
  assign can_launch = mode_act && run_on && step_rise &&
                      (q.fsm == MDS_IDLE) && !sel[3] &&
                      (pick.kind != MDS_SET_INVALID);

  // ***************************************************************
  // Parameter address decode and range checks
  // ***************************************************************
  assign set_off = 10'(i_addr - `MDS_P_SET_BASE);
  assign in_set  = (i_addr >= `MDS_P_SET_BASE) &&
                   (set_off < `MDS_P_SET_SPAN) && !set_off[2];
  assign sn      = set_off[5:3];
  assign fld     = set_off[1:0];
  assign rd_set  = q.store.set[sn];

  assign wr_s    = $signed(i_wr_data);
  assign pos_ok  = (wr_s >= -`MDS_POS_MAX) && (wr_s <= `MDS_POS_MAX);
  assign rate_ok = (i_wr_data >= `MDS_RATE_MIN) &&
                   (i_wr_data <= `MDS_RATE_MAX);
  assign gear_ok = (i_wr_data >= `MDS_RATE_MIN) &&
                   (i_wr_data <= `MDS_GEAR_MAX);

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb begin
    d           = q;
    d.launch    = 1'b0;
    d.rdata     = 32'h0000_0000;
    d.step_prev = step_on;

    // Out-of-range writes are dropped so the store never holds junk
    if (i_wr_en) begin
      if (in_set) begin
        case (fld)
          `MDS_F_TYPE: begin
            if (i_wr_data <= `MDS_TYPE_MAX) begin
              d.store.set[sn].kind = i_wr_data[1:0];
            end
          end
          `MDS_F_POS_LO: begin
            if (pos_ok) begin
              d.store.set[sn].pos_lo = i_wr_data[17:0];
            end
          end
          `MDS_F_POS_HI: begin
            if (pos_ok) begin
              d.store.set[sn].pos_hi = i_wr_data[17:0];
            end
          end
          default: begin
            if (i_wr_data <= `MDS_SPEED_MAX) begin
              d.store.set[sn].speed = i_wr_data[12:0];
            end
          end
        endcase
      end else begin
        case (i_addr)
          `MDS_P_CTRL_MODE: d.store.ctrl_mode = i_wr_data[15:0];
          `MDS_P_STARTUP:   d.store.startup   = i_wr_data[15:0];
          `MDS_P_ACCEL: begin
            if (rate_ok) begin
              d.store.accel = i_wr_data[15:0];
            end
          end
          `MDS_P_DECEL: begin
            if (rate_ok) begin
              d.store.decel = i_wr_data[15:0];
            end
          end
          `MDS_P_EMG_DECEL: begin
            if (rate_ok) begin
              d.store.emg_decel = i_wr_data[15:0];
            end
          end
          `MDS_P_GEAR_NUM: begin
            if (gear_ok) begin
              d.store.gear_num = i_wr_data[15:0];
            end
          end
          `MDS_P_GEAR_DEN: begin
            if (gear_ok) begin
              d.store.gear_den = i_wr_data[15:0];
            end
          end
          `MDS_P_REBOOT: begin
            // Same effect as a power reboot on the working copy
            if (i_wr_data[0]) begin
              d.work = q.store;
              d.fsm  = MDS_IDLE;
            end
          end
          default: ;
        endcase
      end
    end

    if (i_rd_en) begin
      if (in_set) begin
        case (fld)
          `MDS_F_TYPE:   d.rdata = {30'h0, rd_set.kind};
          `MDS_F_POS_LO: d.rdata = 32'($signed(rd_set.pos_lo));
          `MDS_F_POS_HI: d.rdata = 32'($signed(rd_set.pos_hi));
          default:       d.rdata = {19'h0, rd_set.speed};
        endcase
      end else begin
        case (i_addr)
          `MDS_P_CTRL_MODE: d.rdata = {16'h0, q.store.ctrl_mode};
          `MDS_P_STARTUP:   d.rdata = {16'h0, q.store.startup};
          `MDS_P_ACCEL:     d.rdata = {16'h0, q.store.accel};
          `MDS_P_DECEL:     d.rdata = {16'h0, q.store.decel};
          `MDS_P_EMG_DECEL: d.rdata = {16'h0, q.store.emg_decel};
          `MDS_P_GEAR_NUM:  d.rdata = {16'h0, q.store.gear_num};
          `MDS_P_GEAR_DEN:  d.rdata = {16'h0, q.store.gear_den};
          `MDS_P_STATUS:    d.rdata = {20'h0, q.set_num, 2'h0,
                                       q.fsm == MDS_BUSY, q.stop,
                                       run_on, mode_act, step_on,
                                       1'b0};
          default:          d.rdata = 32'h0000_0000;
        endcase
      end
    end

    // Motion control: one set per step edge, host sequences the rest
    d.stop = mode_act && !run_on;
    case (q.fsm)
      MDS_IDLE: begin
        if (can_launch) begin
          d.launch  = 1'b1;
          d.fsm     = MDS_BUSY;
          d.set_num = sel;
          d.kind    = pick.kind;
          d.speed   = pick.speed;
          d.target  = 32'($signed(pick.pos_hi)) * `MDS_POS_SCALE
                    + 32'($signed(pick.pos_lo));
        end
      end
      MDS_BUSY: begin
        if (!run_on || !mode_act || i_move_done) begin
          d.fsm = MDS_IDLE;
        end
      end
      default: d.fsm = MDS_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      q           <= '0;
      q.store     <= mds_defaults();
      q.work      <= mds_defaults();
      q.fsm       <= MDS_IDLE;
    end else begin
      q <= d;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign o_rd_data     = q.rdata;
  assign o_launch      = q.launch;
  assign o_set_num     = q.set_num;
  assign o_set_type    = q.kind;
  assign o_target_pos  = q.target;
  assign o_speed       = q.speed;
  assign o_accel       = q.work.accel;
  assign o_decel       = q.work.decel;
  assign o_emg_decel   = q.work.emg_decel;
  assign o_gear_num    = q.work.gear_num;
  assign o_gear_den    = q.work.gear_den;
  assign o_stop        = q.stop;
  assign o_busy        = (q.fsm == MDS_BUSY);
  assign o_mode_active = mode_act;

endmodule

`default_nettype wire

// *** design/mds_regs.svh ***
`ifndef MDS_REGS_SVH
`define MDS_REGS_SVH

// ***************************************************************
// Parameter numbers, used directly as register addresses
// ***************************************************************
`define MDS_ADDR_W        10
`define MDS_NSETS         8
`define MDS_P_CTRL_MODE   10'h000
`define MDS_P_SET_BASE    10'h2BC
`define MDS_P_SET_SPAN    10'h040
`define MDS_P_STARTUP     10'h2FC
`define MDS_P_ACCEL       10'h2FD
`define MDS_P_DECEL       10'h2FE
`define MDS_P_EMG_DECEL   10'h2FF
`define MDS_P_GEAR_NUM    10'h300
`define MDS_P_GEAR_DEN    10'h301
`define MDS_P_STATUS      10'h3F0
`define MDS_P_REBOOT      10'h3F1

// ***************************************************************
// Field positions and codes
// ***************************************************************
`define MDS_F_TYPE        2'h0
`define MDS_F_POS_LO      2'h1
`define MDS_F_POS_HI      2'h2
`define MDS_F_SPEED       2'h3
`define MDS_MODE_DIGIT_LO 4
`define MDS_MODE_DIGIT_HI 7
`define MDS_MODE_SEQ      4'hC
`define MDS_STARTUP_SINGLE 4'h0

// ***************************************************************
// Ranges and reset values
// ***************************************************************
`define MDS_TYPE_MAX      32'h0000_0002
`define MDS_POS_MAX       32'sh0001_869F
`define MDS_POS_SCALE     32'sh0000_2710
`define MDS_SPEED_MAX     32'h0000_1770
`define MDS_RATE_MIN      32'h0000_0001
`define MDS_RATE_MAX      32'h0000_EA60
`define MDS_GEAR_MAX      32'h0000_FFFF
`define MDS_DEF_ACCEL     16'h2710
`define MDS_DEF_DECEL     16'h2710
`define MDS_DEF_EMG       16'hEA60
`define MDS_DEF_GEAR_NUM  16'h0002
`define MDS_DEF_GEAR_DEN  16'h0001
`define MDS_DEF_CTRL_MODE 16'h0000
`define MDS_DEF_STARTUP   16'h0000

`endif

// *** design/mds_pkg.sv ***
`include "mds_regs.svh"

package mds_pkg;

  typedef enum logic [1:0] {
    MDS_SET_INVALID = 2'h0,
    MDS_SET_ABS     = 2'h1,
    MDS_SET_REL     = 2'h2
  } mds_kind_t;

  typedef enum logic [1:0] {
    MDS_IDLE = 2'b01,
    MDS_BUSY = 2'b10
  } mds_fsm_t;

  typedef struct packed {
    logic [1:0]  kind;
    logic [17:0] pos_lo;
    logic [17:0] pos_hi;
    logic [12:0] speed;
  } mds_set_t;

  typedef struct packed {
    mds_set_t [`MDS_NSETS-1:0] set;
    logic [15:0] accel;
    logic [15:0] decel;
    logic [15:0] emg_decel;
    logic [15:0] gear_num;
    logic [15:0] gear_den;
    logic [15:0] ctrl_mode;
    logic [15:0] startup;
  } mds_params_t;

  function automatic mds_params_t mds_defaults();
    mds_params_t p;
    p           = '0;
    p.accel     = `MDS_DEF_ACCEL;
    p.decel     = `MDS_DEF_DECEL;
    p.emg_decel = `MDS_DEF_EMG;
    p.gear_num  = `MDS_DEF_GEAR_NUM;
    p.gear_den  = `MDS_DEF_GEAR_DEN;
    p.ctrl_mode = `MDS_DEF_CTRL_MODE;
    p.startup   = `MDS_DEF_STARTUP;
    return p;
  endfunction

endpackage

// *** design/mds_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

// ***************************************************************
// Two-flop synchroniser, also used to release the reset
// ***************************************************************
module mds_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= i_d;
      sync_q <= meta_q;
    end
  end

  assign o_q = sync_q;

endmodule

`default_nettype wire

// *** dv/mds_selector_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
// ************
// Launch, stop and read-data checks
// ************
module mds_selector_chk (
  input wire logic        i_clk,
  input wire logic        i_resetn,
  input wire logic        i_rd_en,
  input wire logic [31:0] o_rd_data,
  input wire logic        i_run_enable_n,
  input wire logic        i_move_done,
  input wire logic        o_launch,
  input wire logic [3:0]  o_set_num,
  input wire logic [1:0]  o_set_type,
  input wire logic [31:0] o_target_pos,
  input wire logic        o_stop,
  input wire logic        o_busy,
  input wire logic        o_mode_active
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  AST_LAUNCH_BUSY: assert property (o_launch |-> o_busy)
    else $error("launch without busy");
  AST_BUSY_NO_LAUNCH: assert property (o_busy |=> !o_launch)
    else $error("launch while busy");
  AST_DONE_ENDS: assert property (o_busy && i_move_done |=> !o_busy)
    else $error("busy after move done");
  AST_LAUNCH_MODE: assert property (o_launch |-> o_mode_active)
    else $error("launch with mode off");
  AST_LAUNCH_TYPE: assert property (
    o_launch |-> o_set_type inside {2'h1, 2'h2})
    else $error("launch of invalid set");
  AST_LAUNCH_SET: assert property (o_launch |-> !o_set_num[3])
    else $error("launch of set without data");
  AST_LAUNCH_RUN: assert property (
    o_launch |-> !$past(i_run_enable_n, 3))
    else $error("launch with run off");
  AST_STOP_RUN_OFF: assert property (
    (o_mode_active && i_run_enable_n) [*4] |-> o_stop)
    else $error("no stop with run off");
  AST_STOP_IDLE: assert property (o_stop && $past(o_stop) |-> !o_busy)
    else $error("busy during stop");
  AST_HOLD_SET: assert property (
    !o_launch |-> $stable(o_set_num) && $stable(o_target_pos) &&
                  $stable(o_set_type))
    else $error("set outputs moved without launch");
  AST_RD_QUIET: assert property (!$past(i_rd_en) |-> o_rd_data == '0)
    else $error("read data outside its cycle");
  cover property (o_launch);
  cover property (o_stop && $past(o_busy));
  cover property (o_busy && i_move_done);
endmodule
`default_nettype wire

// *** dv/mds_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ************
// Host controller driving the pins, all ON at low level except o_move_done, which is ON at high level
// ************
module mds_host_model (
  input  wire logic i_clk,
  input  wire logic i_launch,
  output logic      o_set_select_bit0_n,
  output logic      o_set_select_bit1_n,
  output logic      o_set_select_bit2_n,
  output logic      o_set_select_bit3_n,
  output logic      o_run_enable_n,
  output logic      o_step_n,
  output logic      o_move_done
);
  int   done_delay = 2;
  int   cnt_q = 0;
  logic done_q = 1'b0;
  assign o_move_done = done_q;
  initial begin
    {o_set_select_bit3_n, o_set_select_bit2_n} = 2'h3;
    {o_set_select_bit1_n, o_set_select_bit0_n} = 2'h3;
    o_run_enable_n = 1'b1;
    o_step_n = 1'b1;
  end
  // Zero delay means the motion never reports done
  always @(posedge i_clk) begin
    done_q <= (cnt_q == 1);
    if (i_launch && done_delay > 0) begin
      cnt_q <= done_delay;
    end else if (cnt_q > 0) begin
      cnt_q <= cnt_q - 1;
    end
  end
  task automatic set_run(input logic on);
    @(posedge i_clk);
    o_run_enable_n <= !on;
  endtask
  task automatic step(input logic [3:0] sel);
    @(posedge i_clk);
    {o_set_select_bit3_n, o_set_select_bit2_n} <= ~sel[3:2];
    {o_set_select_bit1_n, o_set_select_bit0_n} <= ~sel[1:0];
    repeat (2) @(posedge i_clk);
    o_step_n <= 1'b0;
    repeat (6) @(posedge i_clk);
    o_step_n <= 1'b1;
    // Select lines stay put well past the edge
    repeat (3) @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [9:0]  addr = '0;
  logic [31:0] wdata = '0;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [31:0] rd_data, target;
  logic        s0_n, s1_n, s2_n, s3_n, run_n, step_n, done;
  logic        launch, stop, busy, mact;
  logic [3:0]  set_num;
  logic [1:0]  set_type;
  logic [12:0] speed;
  logic [15:0] accel, decel, emg, gnum, gden;
  int          num_errors = 0;
  int          n_checks = 0;
  int          n_launch = 0;
  int          ty[8], lo[8], hi[8], sp[8];
  int          tbl[15][3] = '{'{700,3,0}, '{700,2,2}, '{701,100000,0},
    '{701,-99999,-99999}, '{702,99999,99999}, '{703,6001,0},
    '{703,6000,6000}, '{765,0,10000}, '{765,60001,10000},
    '{766,60000,60000}, '{767,0,60000}, '{768,0,2},
    '{768,65535,65535}, '{769,65536,1}, '{704,5,0}};

  always #10 clk = ~clk;
  always @(posedge clk) if (launch === 1'b1) n_launch <= n_launch + 1;

  mds_selector dut_u (
    .i_clk(clk), .i_resetn(rstn), .i_addr(addr), .i_wr_data(wdata),
    .i_wr_en(wr_en), .i_rd_en(rd_en), .o_rd_data(rd_data),
    .i_set_select_bit0_n(s0_n), .i_set_select_bit1_n(s1_n),
    .i_set_select_bit2_n(s2_n), .i_set_select_bit3_n(s3_n),
    .i_run_enable_n(run_n), .i_step_n(step_n), .i_move_done(done),
    .o_launch(launch), .o_set_num(set_num), .o_set_type(set_type),
    .o_target_pos(target), .o_speed(speed), .o_accel(accel),
    .o_decel(decel), .o_emg_decel(emg), .o_gear_num(gnum),
    .o_gear_den(gden), .o_stop(stop), .o_busy(busy), .o_mode_active(mact));
  mds_host_model host_u (
    .i_clk(clk), .i_launch(launch), .o_set_select_bit0_n(s0_n),
    .o_set_select_bit1_n(s1_n), .o_set_select_bit2_n(s2_n),
    .o_set_select_bit3_n(s3_n), .o_run_enable_n(run_n),
    .o_step_n(step_n), .o_move_done(done));

  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 60; i++) begin
      settle(1);
      if (busy === 1'b0) return;
    end
    chk("busy timeout", 0, 1);
    end_of_test();
  endtask
  task automatic try(input logic [3:0] s, input logic go);
    int l0;
    l0 = n_launch;
    host_u.step(s);
    chk("launch count", l0 + go, n_launch);
    if (go) begin
      chk("set num", s, set_num);
      chk("set type", ty[s[2:0]], set_type);
      chk("target", hi[s[2:0]] * 10000 + lo[s[2:0]], target);
      chk("speed", sp[s[2:0]], speed);
    end
  endtask

  initial begin
    logic [31:0] d;
    for (int n = 0; n < 8; n++) begin
      ty[n] = (n == 5) ? 0 : (n % 2) + 1;
      lo[n] = (n == 7) ? 99999 : n * 1000 - 3000;
      hi[n] = (n == 0) ? -99999 : 3 - n;
      sp[n] = (n == 7) ? 6000 : n * 700;
    end
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    settle(6);
    chk("accel", 10000, accel);
    chk("decel", 10000, decel);
    chk("emg decel", 60000, emg);
    chk("gear", 32'h0002_0001, {gnum, gden});
    foreach (tbl[i]) begin
      wr(10'(tbl[i][0]), tbl[i][1]);
      rd(10'(tbl[i][0]), d);
      chk("param", tbl[i][2], d);
    end
    for (int n = 0; n < 8; n++) begin
      wr(10'(700 + 8 * n), ty[n]);
      wr(10'(701 + 8 * n), lo[n]);
      wr(10'(702 + 8 * n), hi[n]);
      wr(10'(703 + 8 * n), sp[n]);
    end
    chk("decel", 10000, decel);
    wr(10'd1009, 1);
    settle(3);
    chk("gear", 32'hFFFF_0001, {gnum, gden});
    chk("decel", 60000, decel);
    host_u.set_run(1);
    try(1, 0);
    wr(10'd0, 32'h0000_00C0);
    wr(10'd1009, 1);
    settle(3);
    chk("mode", 1, mact);
    host_u.done_delay = 0;
    try(1, 1);
    try(2, 0);
    chk("held set", 1, set_num);
    rd(10'd1008, d);
    chk("status", 32'h0000_012C, d);
    host_u.set_run(0);
    settle(5);
    chk("stop busy", 2'b10, {stop, busy});
    host_u.set_run(1);
    settle(5);
    chk("stop", 0, stop);
    host_u.done_delay = 2;
    try(9, 0);
    for (int n = 0; n < 8; n++) begin
      host_u.done_delay = (n % 2) ? 25 : 2;
      try(4'(n), n != 5);
      wait_idle();
    end
    // Any startup manner other than single switches the block off
    wr(10'd764, 1);
    wr(10'd1009, 1);
    settle(3);
    chk("mode", 0, mact);
    try(1, 0);
    end_of_test();
  end
  initial begin
    #1_000_000;
    chk("watchdog", 0, 1);
    end_of_test();
  end
endmodule
bind mds_selector mds_selector_chk chk_u (.i_clk, .i_resetn, .i_rd_en,
  .o_rd_data, .i_run_enable_n, .i_move_done, .o_launch, .o_set_num,
  .o_set_type, .o_target_pos, .o_stop, .o_busy, .o_mode_active);
`default_nettype wire
